// file: hw/vic_params.svh
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH
`define VIC_NUM_MASKABLE   11
`define VIC_ENTRY_ADDR     15'h00FF
`define VIC_ACK_CYCLES     3'h7
`define VIC_ADDR_W         15
`define VIC_VEC_LO_BYTE    8'hE0
`define VIC_VEC_TRAP_BYTE  8'hFE
`define VIC_RST_PEND       11'h000
`define VIC_RST_EN         11'h000
`endif

// file: hw/vic_pkg.sv
package vic_pkg;
  typedef enum logic [1:0] {
    VIC_IDLE = 2'b00,
    VIC_ACK  = 2'b01
  } vic_state_t;

  typedef struct packed {
    logic        valid;
    logic [14:0] addr;
  } vic_pc_load_t;

  typedef struct packed {
    logic [10:0] wdata;
    logic        we;
  } vic_sw_wr_t;
endpackage

// file: hw/vic_prio_enc.sv
`timescale 1ns/1ps
`include "vic_params.svh"
// Picks the highest ranked active source; index 0 ranks highest.
module vic_prio_enc
  import vic_pkg::*;
(
  input  wire logic [10:0] active,
  output logic             any,
  output logic [3:0]       idx
);
  always_comb begin
    any = 1'b0;
    idx = 4'hF;
    for (int i = `VIC_NUM_MASKABLE - 1; i >= 0; i--) begin
      if (active[i]) begin
        any = 1'b1;
        idx = 4'(i);
      end
    end
  end
endmodule

// file: hw/vic_top.sv
`timescale 1ns/1ps
`include "vic_params.svh"
// Overview of operation
// - Acknowledge loads PC with entry 00FF
// - Trap ranks highest, default VECTOR_SELECT_INSTRUCTION entry lowest
// - Eleven maskable inputs with fixed rank, vector
// - Maskables have software enable and pending bits
// - Source event sets pending regardless of enable
// - Trigger needs pending, enable, global, no trap
// - Judge at instruction start; highest wins first
// - Reset clears pending, enables, global enable
// - Already pending source triggers once enabled
// - Skip completes before acknowledging late request
// - Acknowledge start clears global enable
// - Push address of next instruction during acknowledge
// - Acknowledge sequence lasts seven instruction cycles
// - Writing global enable inside a maskable routine allows nesting; in a trap routine it waits for trap_done
// - Return sets global enable; the next start rearbitrates
// - VECTOR_SELECT_INSTRUCTION vectors to trap, else best active, else default
module vic_top
  import vic_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [10:0] irq_src,
  input  wire logic        sw_trap,
  input  wire logic        instr_start,
  input  wire logic        skip_pending,
  input  wire logic [14:0] next_instr_addr,
  input  wire vic_sw_wr_t  pend_wr,
  input  wire vic_sw_wr_t  en_wr,
  input  wire logic        gie_wr,
  input  wire logic        gie_wdata,
  input  wire logic        return_from_irq_instruction,
  input  wire logic        vector_select_instruction,
  input  wire logic        trap_done,
  input  wire logic [7:0]  vis_page,
  output logic [10:0]      pending_flags,
  output logic [10:0]      enable_bits,
  output logic             global_irq_enable,
  output logic             ack_busy,
  output logic             stack_push,
  output logic [14:0]      stack_push_data,
  output vic_pc_load_t     pc_load,
  output logic [14:0]      vis_vector_addr,
  output logic             vis_vector_valid
);
  logic [10:0]   src_s1_q, src_s2_q, src_s3_q;
  logic          trap_s1_q, trap_s2_q;
  logic [10:0]   pend_q, pend_d;
  logic [10:0]   en_q, en_d;
  logic          gie_q, gie_d;
  logic          trap_pend_q, trap_pend_d;
  logic          in_trap_q, in_trap_d;
  vic_state_t    state_q, state_d;
  logic [2:0]    cnt_q, cnt_d;
  logic          push_q, push_d;
  logic [14:0]   push_data_q, push_data_d;
  vic_pc_load_t  pcl_q, pcl_d;
  logic [14:0]   vis_addr_q, vis_addr_d;
  logic          vis_v_q, vis_v_d;
  logic [10:0]   active;
  logic          any_active;
  logic [3:0]    best_idx;
  logic [10:0]   src_rise;
  logic          start_ok;

  // Sources are asynchronous events; synchronise before edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      src_s1_q  <= 11'h000;
      src_s2_q  <= 11'h000;
      src_s3_q  <= 11'h000;
      trap_s1_q <= 1'b0;
      trap_s2_q <= 1'b0;
    end else begin
      src_s1_q  <= irq_src;
      src_s2_q  <= src_s1_q;
      src_s3_q  <= src_s2_q;
      trap_s1_q <= sw_trap;
      trap_s2_q <= trap_s1_q;
    end
  end

  assign src_rise = src_s2_q & ~src_s3_q;
  assign active   = pend_q & en_q;
  // A start that meets a return waits for the next one, which sees the enable set again
  assign start_ok = instr_start && !skip_pending && !return_from_irq_instruction;

  vic_prio_enc u_prio (
    .active (active),
    .any    (any_active),
    .idx    (best_idx)
  );

  always_comb begin
    pend_d      = pend_q;
    en_d        = en_q;
    gie_d       = gie_q;
    trap_pend_d = trap_pend_q | trap_s2_q;
    in_trap_d   = in_trap_q & ~trap_done;
    state_d     = state_q;
    cnt_d       = cnt_q;
    push_d      = 1'b0;
    push_data_d = push_data_q;
    pcl_d       = '0;
    if (pend_wr.we) begin
      pend_d = pend_wr.wdata;
    end
    pend_d = pend_d | src_rise;
    if (en_wr.we) begin
      en_d = en_wr.wdata;
    end
    if (gie_wr) begin
      gie_d = gie_wdata;
    end
    if (return_from_irq_instruction) begin
      gie_d = 1'b1;
    end
    case (state_q)
      VIC_IDLE: begin
        // Trigger judged only at a real instruction start, after any skip
        if (start_ok) begin
          if (trap_pend_q) begin
            trap_pend_d = trap_s2_q;
            in_trap_d   = 1'b1;
            state_d     = VIC_ACK;
          end else if (gie_q && !in_trap_q && any_active) begin
            state_d = VIC_ACK;
          end
          // Return address is the instruction the core was about to run
          if (state_d == VIC_ACK) begin
            gie_d       = 1'b0;
            cnt_d       = 3'h1;
            push_d      = 1'b1;
            push_data_d = next_instr_addr;
          end
        end
      end
      VIC_ACK: begin
        // Enable is forced low through the sequence; a software write raises it for one clock only
        gie_d = (gie_q && !gie_wr) ? 1'b0 : gie_d;
        // The taking start is cycle one; the sixth start after it closes the sequence
        if (instr_start) begin
          if (cnt_q == `VIC_ACK_CYCLES - 3'h1) begin
            pcl_d.valid = 1'b1;
            pcl_d.addr  = `VIC_ENTRY_ADDR;
            state_d     = VIC_IDLE;
          end else begin
            cnt_d = cnt_q + 3'h1;
          end
        end
      end
      default: begin
        state_d = VIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_q      <= `VIC_RST_PEND;
      en_q        <= `VIC_RST_EN;
      gie_q       <= 1'b0;
      trap_pend_q <= 1'b0;
      in_trap_q   <= 1'b0;
      state_q     <= VIC_IDLE;
      cnt_q       <= 3'h0;
      push_q      <= 1'b0;
      push_data_q <= 15'h0000;
      pcl_q       <= '0;
    end else begin
      pend_q      <= pend_d;
      en_q        <= en_d;
      gie_q       <= gie_d;
      trap_pend_q <= trap_pend_d;
      in_trap_q   <= in_trap_d;
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      push_q      <= push_d;
      push_data_q <= push_data_d;
      pcl_q       <= pcl_d;
    end
  end

  // Vector choice; a trap that is pending or in service outranks every maskable
  always_comb begin
    vis_addr_d = vis_addr_q;
    vis_v_d    = 1'b0;
    if (vector_select_instruction) begin
      vis_v_d = 1'b1;
      if (in_trap_q || trap_pend_q) begin
        vis_addr_d = {vis_page[6:0], `VIC_VEC_TRAP_BYTE};
      end else if (any_active) begin
        vis_addr_d = {vis_page[6:0], 8'(`VIC_VEC_TRAP_BYTE - 8'h04 - {best_idx, 1'b0})};
      end else begin
        vis_addr_d = {vis_page[6:0], `VIC_VEC_LO_BYTE};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vis_addr_q <= 15'h0000;
      vis_v_q    <= 1'b0;
    end else begin
      vis_addr_q <= vis_addr_d;
      vis_v_q    <= vis_v_d;
    end
  end

  assign pending_flags     = pend_q;
  assign enable_bits       = en_q;
  assign global_irq_enable = gie_q;
  assign ack_busy          = (state_q == VIC_ACK);
  assign stack_push        = push_q;
  assign stack_push_data   = push_data_q;
  assign pc_load           = pcl_q;
  assign vis_vector_addr   = vis_addr_q;
  assign vis_vector_valid  = vis_v_q;
endmodule

// file: sim/vic_chk.sv
`timescale 1ns/1ps
module vic_chk
  import vic_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire logic         instr_start,
  input wire logic         skip_pending,
  input wire logic [14:0]  next_instr_addr,
  input wire logic         global_irq_enable,
  input wire logic         ack_busy,
  input wire logic         stack_push,
  input wire logic [14:0]  stack_push_data,
  input wire vic_pc_load_t pc_load
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Starts seen since the push; the entry jump belongs to the sixth
  always_comb begin
    cnt_d = cnt_q;
    if (stack_push) cnt_d = 3'h0;
    else if (ack_busy && instr_start) cnt_d = cnt_q + 3'h1;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cnt_q <= 3'h0;
    else cnt_q <= cnt_d;
  end
  sequence s_ack_end; ##[1:40] pc_load.valid; endsequence
  property p_pc_addr; pc_load.valid |-> pc_load.addr == 15'h00FF; endproperty
  a_pc_addr: assert property (p_pc_addr) else $error("entry address wrong");
  property p_push_data; stack_push |-> stack_push_data == $past(next_instr_addr); endproperty
  a_push_data: assert property (p_push_data) else $error("pushed address wrong");
  property p_gie_clr; stack_push |-> !global_irq_enable; endproperty
  a_gie_clr: assert property (p_gie_clr) else $error("global enable kept");
  property p_take; stack_push |-> $past(instr_start && !ack_busy); endproperty
  a_take: assert property (p_take) else $error("ack off instruction start");
  property p_skip; instr_start && skip_pending |=> !stack_push; endproperty
  a_skip: assert property (p_skip) else $error("ack on skipped start");
  property p_busy; stack_push |-> ack_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
  property p_end; stack_push |-> s_ack_end; endproperty
  a_end: assert property (p_end) else $error("ack never ends");
  property p_cnt; pc_load.valid |-> cnt_q == 3'h6; endproperty
  a_cnt: assert property (p_cnt) else $error("ack length wrong");
endmodule
bind vic_top vic_chk u_chk (.*);

// file: sim/vic_core_model.sv
`timescale 1ns/1ps
// Core issues one instruction every four clocks, address stepping by one
module vic_core_model (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  output logic       instr_start,
  output logic [14:0] next_instr_addr
);
  logic [1:0] ph_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_q <= 2'h0;
      instr_start <= 1'b0;
      next_instr_addr <= 15'h0100;
    end else begin
      ph_q <= ph_q + 2'h1;
      instr_start <= (ph_q == 2'h3);
      if (ph_q == 2'h3) next_instr_addr <= next_instr_addr + 15'h0001;
    end
  end
endmodule

// file: sim/vic_top_tb.sv
`timescale 1ns/1ps
module vic_top_tb;
  import vic_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, sw_trap = 1'b0, skip_pending = 1'b0, trap_done = 1'b0;
  logic [10:0] irq_src = 11'h000, pending_flags, enable_bits;
  logic instr_start, global_irq_enable, ack_busy, stack_push, vis_vector_valid;
  logic gie_wr = 1'b0, gie_wdata = 1'b0;
  logic return_from_irq_instruction = 1'b0, vector_select_instruction = 1'b0;
  logic [14:0] next_instr_addr, stack_push_data, vis_vector_addr;
  logic [7:0] vis_page = 8'h01;
  vic_sw_wr_t pend_wr = '0, en_wr = '0;
  vic_pc_load_t pc_load;
  int n_fail = 0, compares = 0;
  always #4 ref_clk = ~ref_clk;
  vic_top dut (.*);
  vic_core_model u_core (.*);
  task automatic chk(input string nm, input logic [14:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Bounded wait: k=0 for the entry jump, k=1 for the vector
  task automatic wt(input bit k);
    for (int i = 0; i < 60 && (k ? vis_vector_valid : pc_load.valid) !== 1'b1; i++) cyc(1);
    if ((k ? vis_vector_valid : pc_load.valid) !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic t_ack;
    chk("pend", pending_flags, 0);
    chk("gie", global_irq_enable, 0);
    irq_src <= 11'h008;
    cyc(8);
    chk("pend", pending_flags, 11'h008);
    en_wr <= '{11'h008, 1'b1};
    cyc(1);
    en_wr.we <= 1'b0;
    cyc(10);
    chk("busy", ack_busy, 0);
    chk("en", enable_bits, 11'h008);
    skip_pending <= 1'b1;
    gie_wr <= 1'b1;
    gie_wdata <= 1'b1;
    cyc(1);
    gie_wr <= 1'b0;
    cyc(10);
    chk("skip", ack_busy, 0);
    skip_pending <= 1'b0;
    wt(0);
    chk("pc", pc_load.addr, 15'h00FF);
    chk("gie", global_irq_enable, 0);
    $display("t_ack done");
  endtask
  task automatic t_vis;
    pend_wr <= '{11'h000, 1'b1};
    irq_src <= 11'h000;
    cyc(1);
    pend_wr.we <= 1'b0;
    vector_select_instruction <= 1'b1;
    cyc(1);
    vector_select_instruction <= 1'b0;
    wt(1);
    chk("vdef", vis_vector_addr, 15'h01E0);
    irq_src <= 11'h00A;
    en_wr <= '{11'h00A, 1'b1};
    cyc(1);
    en_wr.we <= 1'b0;
    cyc(8);
    vector_select_instruction <= 1'b1;
    cyc(1);
    vector_select_instruction <= 1'b0;
    wt(1);
    chk("vbest", vis_vector_addr, 15'h01F8);
    return_from_irq_instruction <= 1'b1;
    cyc(1);
    return_from_irq_instruction <= 1'b0;
    wt(0);
    chk("nest", global_irq_enable, 0);
    chk("left", pending_flags, 11'h00A);
    $display("t_vis done");
  endtask
  task automatic t_trap;
    sw_trap <= 1'b1;
    cyc(1);
    sw_trap <= 1'b0;
    wt(0);
    chk("tpc", pc_load.addr, 15'h00FF);
    vector_select_instruction <= 1'b1;
    cyc(1);
    vector_select_instruction <= 1'b0;
    wt(1);
    chk("vtrap", vis_vector_addr, 15'h01FE);
    gie_wr <= 1'b1;
    gie_wdata <= 1'b1;
    cyc(1);
    gie_wr <= 1'b0;
    cyc(12);
    chk("hold", ack_busy, 0);
    chk("hgie", global_irq_enable, 1);
    trap_done <= 1'b1;
    cyc(1);
    trap_done <= 1'b0;
    wt(0);
    chk("after", global_irq_enable, 0);
    $display("t_trap done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(2);
    t_ack();
    t_vis();
    t_trap();
    complete_run();
  end
endmodule
